/* logic/ebmp_clkdiv.sv */
// Timer acting as processor clock divider in low power mode
`timescale 1ns/1ps
module ebmp_clkdiv #(
    parameter int TW = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    ebmp_div_if.div  dv
);
    typedef struct packed {
        logic [TW-1:0] cnt;
        logic          tick;
    } ebmp_div_t;

    ebmp_div_t s;
    ebmp_div_t next_s;

    if (TW < 2) begin : g_chk
        $error("ebmp_clkdiv: TW must be at least 2");
    end

    always_comb begin
        next_s = s;
        if (!dv.slow) begin
            next_s.tick = 1'b1;
            next_s.cnt  = dv.load;
        end else if (s.cnt == '0) begin
            next_s.tick = 1'b1;
            next_s.cnt  = dv.load;
        end else begin
            next_s.tick = 1'b0;
            next_s.cnt  = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s      <= '0;
            // Full rate enable from the first edge after reset
            s.tick <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign dv.tick = s.tick;

    a_fast_rate: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !dv.slow |=> dv.tick)
        else $error("full rate mode lost a clock enable");

    a_div_gap: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (dv.slow && s.cnt != '0) |=> !dv.tick)
        else $error("divider ticked before count ran out");

    a_div_reload: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (dv.slow && s.cnt == '0) |=> (dv.tick && s.cnt == $past(dv.load)))
        else $error("divider did not tick and reload");
endmodule

/* logic/ebmp_div_if.sv */
// Link between control logic and the clock divider
`timescale 1ns/1ps
interface ebmp_div_if #(parameter int TW = 16);
    logic          slow;
    logic [TW-1:0] load;
    logic          tick;
    modport ctl (output slow, output load, input tick);
    modport div (input slow, input load, output tick);
endinterface

/* logic/ebmp_pkg.sv */
// Constants, decode helper and phase type for the expansion bus block
package ebmp_pkg;
    localparam int unsigned AXI_AW = 12;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTL   = 10'h0f7;
    localparam logic [9:0] IDX_TMR   = 10'h0f8;
    localparam logic [9:0] IDX_TMRH  = 10'h0f9;
    localparam logic [9:0] IDX_PORTA = 10'h0f0;
    localparam logic [9:0] IDX_SET   = 10'h0e0;
    localparam logic [9:0] IDX_CLR   = 10'h0e1;

    // Control register fields and the port A clock gate bit
    localparam int unsigned CTL_SLOW = 3;
    localparam int unsigned CTL_BDE  = 5;
    localparam int unsigned CTL_NMI  = 7;
    localparam int unsigned GATE_BIT = 0;

    localparam logic [7:0]  CTL_RST = 8'h00;
    localparam logic [15:0] TMR_RST = 16'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Memory map
    localparam logic [15:0] ROM_BASE  = 16'hf800;
    localparam logic [15:0] IO_BASE   = 16'h00f0;
    localparam logic [15:0] IO_TOP    = 16'h00ff;
    localparam logic [15:0] RAM0_BASE = 16'h00c0;
    localparam logic [15:0] RAM0_TOP  = 16'h00ef;
    localparam logic [15:0] RAM1_BASE = 16'h01c0;
    localparam logic [15:0] RAM1_TOP  = 16'h01ff;

    typedef enum logic [1:0] {
        EBMP_PH0 = 2'h0,
        EBMP_PH1 = 2'h1,
        EBMP_PH2 = 2'h3,
        EBMP_PH3 = 2'h2
    } ebmp_phase_t;

    // High when read data comes from the on-chip side
    function automatic logic ebmp_from_int(input logic [15:0] a,
                                           input logic        test,
                                           input logic        xsel);
        logic top;
        top = (a >= ROM_BASE);
        ebmp_from_int = (top && !(test && xsel))
                     || (a >= IO_BASE && a <= IO_TOP)
                     || (a >= RAM0_BASE && a <= RAM0_TOP)
                     || (a >= RAM1_BASE && a <= RAM1_TOP);
    endfunction
endpackage

/* logic/ebmp_top.sv */
// Expansion bus, memory map and power control with AXI4-Lite registers
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module ebmp_top #(
    parameter int              PW       = 8,
    parameter logic [PW-1:0]   IN_MASK  = 8'hff,
    parameter logic [PW-1:0]   OUT_MASK = 8'hff,
    parameter int              TW       = 16
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [ebmp_pkg::AXI_AW-1:0] awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [ebmp_pkg::AXI_AW-1:0] araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    input  wire logic                        cpu_valid,
    input  wire logic                        cpu_write,
    input  wire logic [15:0]                 cpu_addr,
    input  wire logic [7:0]                  cpu_wdata,
    input  wire logic [7:0]                  int_rdata,
    output logic [7:0]                       cpu_rdata,
    output logic                             cpu_rvalid,
    output logic                             cpu_clk_en,
    output logic [15:0]                      ext_addr,
    output logic                             ext_addr_oe,
    output logic [7:0]                       ext_data_o,
    input  wire logic [7:0]                  ext_data_i,
    output logic                             ext_data_oe,
    output logic                             ext_read,
    output logic                             ext_phase2,
    output logic                             ext_phase4,
    input  wire logic                        bus_enable,
    input  wire logic                        port_d_bit_one,
    input  wire logic                        power_fail,
    input  wire logic [PW-1:0]               port_a_i,
    output logic [PW-1:0]                    port_a_o,
    output logic [PW-1:0]                    port_a_oe,
    output logic                             clock_gate_port_bit,
    output logic                             test_mode
);
    typedef struct packed {
        ebmp_pkg::ebmp_phase_t       ph;
        logic                        seen;
        logic                        test;
        logic                        xsel;
        logic [7:0]                  ctl;
        logic [15:0]                 tmr;
        logic [PW-1:0]               pa;
        logic [PW-1:0]               pa_oe;
        logic                        aw_got;
        logic                        w_got;
        logic [ebmp_pkg::AXI_AW-1:0] awa;
        logic [31:0]                 wd;
        logic [3:0]                  ws;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [1:0]                  rresp;
        logic [31:0]                 rdata;
        logic                        cpu_en;
        logic [15:0]                 xa;
        logic [7:0]                  xd;
        logic                        xread;
        logic                        xaoe;
        logic                        xdoe;
        logic                        rd_pend;
        logic                        rd_int;
        logic [7:0]                  crd;
        logic                        crv;
    } ebmp_st_t;

    localparam logic [PW-1:0] OUT_ONLY = OUT_MASK & ~IN_MASK;
    localparam logic [PW-1:0] BIDIR    = OUT_MASK & IN_MASK;
    localparam logic [PW-1:0] PIN_MASK = OUT_MASK | IN_MASK;

    ebmp_st_t s;
    ebmp_st_t next_s;
    logic     active;
    logic [7:0] ctl_rd;

    ebmp_div_if #(.TW(TW)) dv ();

    if (PW < 1 || PW > 8 || TW != 16) begin : g_chk
        $error("ebmp_top: PW must be 1..8 and TW must be 16");
    end

    ebmp_clkdiv #(.TW(TW)) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dv      (dv)
    );

    assign dv.slow = s.ctl[ebmp_pkg::CTL_SLOW];
    assign dv.load = s.tmr;

    // Test mode forces the bus on whatever software did
    assign active = s.ctl[ebmp_pkg::CTL_BDE] || s.test;

    always_comb begin
        ctl_rd = s.ctl;
        ctl_rd[ebmp_pkg::CTL_NMI] = power_fail;
    end

    always_comb begin
        next_s = s;

        // Strap caught on the first edge after reset release
        if (!s.seen) begin
            next_s.seen = 1'b1;
            next_s.test = !bus_enable;
        end
        next_s.xsel = port_d_bit_one;

        // Write channels, accepted in either order
        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awa    = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wd    = wdata;
            next_s.ws    = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = ebmp_pkg::RESP_OKAY;
            case (s.awa[11:2])
                ebmp_pkg::IDX_CTL: begin
                    if (s.ws[0]) next_s.ctl = s.wd[7:0];
                end
                ebmp_pkg::IDX_SET: begin
                    if (s.ws[0]) next_s.ctl = s.ctl | s.wd[7:0];
                end
                ebmp_pkg::IDX_CLR: begin
                    if (s.ws[0]) next_s.ctl = s.ctl & ~s.wd[7:0];
                end
                ebmp_pkg::IDX_TMR: begin
                    if (s.ws[0]) next_s.tmr[7:0]  = s.wd[7:0];
                    if (s.ws[1]) next_s.tmr[15:8] = s.wd[15:8];
                end
                ebmp_pkg::IDX_TMRH: begin
                    if (s.ws[0]) next_s.tmr[15:8] = s.wd[7:0];
                end
                ebmp_pkg::IDX_PORTA: begin
                    if (s.ws[0]) next_s.pa = s.wd[PW-1:0];
                end
                default: begin
                    next_s.bresp = ebmp_pkg::RESP_DECERR;
                end
            endcase
            // Status bit is never stored; it always shows the pin
            next_s.ctl[ebmp_pkg::CTL_NMI] = 1'b0;
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready  = !next_s.w_got && !next_s.bvalid;

        // Read channel, one read under way at a time
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = ebmp_pkg::RESP_OKAY;
            next_s.rdata  = '0;
            case (araddr[11:2])
                ebmp_pkg::IDX_CTL,
                ebmp_pkg::IDX_SET,
                ebmp_pkg::IDX_CLR: begin
                    next_s.rdata[7:0] = ctl_rd;
                end
                ebmp_pkg::IDX_TMR: begin
                    next_s.rdata[15:0] = s.tmr;
                end
                ebmp_pkg::IDX_TMRH: begin
                    next_s.rdata[7:0] = s.tmr[15:8];
                end
                ebmp_pkg::IDX_PORTA: begin
                    // Pins, not the latch
                    next_s.rdata[PW-1:0] = port_a_i & PIN_MASK;
                end
                default: begin
                    next_s.rresp = ebmp_pkg::RESP_DECERR;
                end
            endcase
        end
        next_s.arready = !next_s.rvalid;

        // Processor clock enable and bus phases
        next_s.cpu_en = dv.tick;
        if (dv.tick) begin
            case (s.ph)
                ebmp_pkg::EBMP_PH0: next_s.ph = ebmp_pkg::EBMP_PH1;
                ebmp_pkg::EBMP_PH1: next_s.ph = ebmp_pkg::EBMP_PH2;
                ebmp_pkg::EBMP_PH2: next_s.ph = ebmp_pkg::EBMP_PH3;
                ebmp_pkg::EBMP_PH3: next_s.ph = ebmp_pkg::EBMP_PH0;
                default:            next_s.ph = ebmp_pkg::EBMP_PH0;
            endcase
        end

        // Every access goes out while the bus is active (enable bit or test mode), so overlay memory sees all cycles
        next_s.xaoe = active;
        if (cpu_valid) begin
            next_s.xa    = cpu_addr;
            next_s.xd    = cpu_wdata;
            next_s.xread = !cpu_write;
        end
        next_s.xdoe = active && cpu_valid && cpu_write;

        // Select pin only chooses where read data comes from
        next_s.rd_pend = cpu_valid && !cpu_write;
        next_s.rd_int  = ebmp_pkg::ebmp_from_int(cpu_addr, s.test,
                                                 s.xsel);
        next_s.crv = s.rd_pend;
        if (s.rd_pend) begin
            next_s.crd = s.rd_int ? int_rdata : ext_data_i;
        end

        // Bidir lines drive low only, wire-or style
        next_s.pa_oe = OUT_ONLY | (BIDIR & ~next_s.pa);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s       <= '0;
            s.ph    <= ebmp_pkg::EBMP_PH0;
            s.ctl   <= ebmp_pkg::CTL_RST;
            s.tmr   <= ebmp_pkg::TMR_RST;
            s.pa    <= '1;
            s.pa_oe <= OUT_ONLY;
            s.xsel  <= 1'b1;
            s.xread <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign awready             = s.awready;
    assign wready              = s.wready;
    assign bvalid              = s.bvalid;
    assign bresp               = s.bresp;
    assign arready             = s.arready;
    assign rvalid              = s.rvalid;
    assign rresp               = s.rresp;
    assign rdata               = s.rdata;
    assign cpu_rdata           = s.crd;
    assign cpu_rvalid          = s.crv;
    assign cpu_clk_en          = s.cpu_en;
    assign ext_addr            = s.xa;
    assign ext_addr_oe         = s.xaoe;
    assign ext_data_o          = s.xd;
    assign ext_data_oe         = s.xdoe;
    assign ext_read            = s.xread;
    assign ext_phase2          = s.ph[1];
    assign ext_phase4          = s.ph[0];
    assign port_a_o            = s.pa;
    assign port_a_oe           = s.pa_oe;
    assign clock_gate_port_bit = s.pa[ebmp_pkg::GATE_BIT];
    assign test_mode           = s.test;

    a_bus_gated: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!s.ctl[ebmp_pkg::CTL_BDE] && !s.test)
            |=> (!ext_addr_oe && !ext_data_oe))
        else $error("expansion bus driven while disabled");

    a_test_bus_on: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s.seen && s.test) |=> ext_addr_oe)
        else $error("bus inactive in test mode");

    a_top_driven: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (cpu_valid && active && cpu_addr >= ebmp_pkg::ROM_BASE)
            |=> (ext_addr_oe && ext_addr == $past(cpu_addr)))
        else $error("top region access missing from bus");

    a_ext_rom: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (cpu_valid && !cpu_write && cpu_addr >= ebmp_pkg::ROM_BASE
            && s.test && s.xsel)
            |=> ##1 (cpu_rvalid && cpu_rdata == $past(ext_data_i)))
        else $error("external program data not returned");

    a_int_rom: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (cpu_valid && !cpu_write && cpu_addr >= ebmp_pkg::ROM_BASE
            && !s.test)
            |=> ##1 (cpu_rvalid && cpu_rdata == $past(int_rdata)))
        else $error("internal program data not returned");

    a_io_internal: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (cpu_valid && !cpu_write && cpu_addr >= ebmp_pkg::IO_BASE
            && cpu_addr <= ebmp_pkg::IO_TOP)
            |=> ##1 (cpu_rdata == $past(int_rdata)))
        else $error("I/O read taken from outside");

    a_pin_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && araddr[11:2] == ebmp_pkg::IDX_PORTA)
            |=> (rvalid && rdata[PW-1:0] == ($past(port_a_i) & PIN_MASK)))
        else $error("port read did not show pins");

    a_nmi_status: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready && araddr[11:2] == ebmp_pkg::IDX_CTL)
            |=> (rdata[ebmp_pkg::CTL_NMI] == $past(power_fail)))
        else $error("status bit does not follow power fail");

    a_set_keeps: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s.aw_got && s.w_got && s.ws[0]
            && s.awa[11:2] == ebmp_pkg::IDX_SET)
            |=> ((s.ctl & $past(s.ctl)) == ($past(s.ctl)
                & ~(8'h01 << ebmp_pkg::CTL_NMI))))
        else $error("bit set write disturbed other bits");

    a_reset_gate: assert property (
        @(posedge aclk)
        !aresetn |=> clock_gate_port_bit)
        else $error("reset did not release the clock gate");
endmodule

/* test/ebmp_ext_mem.sv */
// External ROM/RAM model sitting on the expansion bus
`timescale 1ns/1ps
module ebmp_ext_mem (
    input  wire logic        aclk,
    input  wire logic [15:0] ext_addr,
    input  wire logic        ext_addr_oe,
    input  wire logic [7:0]  ext_data_o,
    input  wire logic        ext_data_oe,
    input  wire logic        ext_read,
    output logic      [7:0]  ext_data_i
);
    logic [7:0] mem [256];
    logic [7:0] last;

    initial begin
        last = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end

    // Released bus toggles so stale data never looks valid
    assign ext_data_i = (ext_addr_oe && ext_read) ? mem[ext_addr[7:0]]
                                                  : ~last;

    always @(posedge aclk) begin
        last <= ext_data_i;
        if (ext_addr_oe && !ext_read && ext_data_oe) begin
            mem[ext_addr[7:0]] <= ext_data_o;
        end
    end
endmodule

/* test/tb.sv */
// Self-checking bench for the expansion bus and power control block
`timescale 1ns/1ps
module tb;
    localparam logic [11:0] A_CTL  = {ebmp_pkg::IDX_CTL, 2'b00};
    localparam logic [11:0] A_TMR  = {ebmp_pkg::IDX_TMR, 2'b00};
    localparam logic [11:0] A_TMRH = {ebmp_pkg::IDX_TMRH, 2'b00};
    localparam logic [11:0] A_PA   = {ebmp_pkg::IDX_PORTA, 2'b00};
    localparam logic [11:0] A_SET  = {ebmp_pkg::IDX_SET, 2'b00};
    localparam logic [11:0] A_CLR  = {ebmp_pkg::IDX_CLR, 2'b00};

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        bready = 1'b1;
    logic        rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        cpu_valid = 1'b0;
    logic        cpu_write = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [7:0]  int_rdata = 8'hc3;
    logic [7:0]  cpu_rdata, ext_data_o, ext_data_i, port_a_o, port_a_oe;
    logic        cpu_rvalid, cpu_clk_en, ext_addr_oe, ext_data_oe;
    logic        ext_read, ext_phase2, ext_phase4;
    logic [15:0] ext_addr;
    logic        bus_enable = 1'b1;
    logic        port_d_bit_one = 1'b1;
    logic        power_fail = 1'b0;
    logic [7:0]  pa_pins = 8'h3c;
    wire  [7:0]  port_a_i;
    logic        clock_gate_port_bit, test_mode;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          n, ph;
    logic [31:0] rd;
    logic [1:0]  rr, wr;
    logic        oe_s, doe_s, rv_s;
    logic [15:0] ad_s;
    logic [7:0]  rd_s;

    // A driven-low latch bit pulls the pin down
    assign port_a_i = pa_pins & (~port_a_oe | port_a_o);

    ebmp_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cpu_valid,
        .cpu_write, .cpu_addr, .cpu_wdata, .int_rdata, .cpu_rdata,
        .cpu_rvalid, .cpu_clk_en, .ext_addr, .ext_addr_oe, .ext_data_o,
        .ext_data_i, .ext_data_oe, .ext_read, .ext_phase2, .ext_phase4,
        .bus_enable, .port_d_bit_one, .power_fail, .port_a_i, .port_a_o,
        .port_a_oe, .clock_gate_port_bit, .test_mode);

    ebmp_ext_mem ext_mem (.aclk, .ext_addr, .ext_addr_oe, .ext_data_o,
        .ext_data_oe, .ext_read, .ext_data_i);

    initial begin
        forever #10 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic rst(input logic be);
        aresetn <= 1'b0;
        bus_enable <= be;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        bus_enable <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    task automatic axw(input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!dd && wready) begin
                dd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        wr = bresp;
    endtask

    task automatic axr(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
    endtask

    task automatic cpu(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        cpu_valid <= 1'b1;
        cpu_write <= w;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge aclk);
        cpu_valid <= 1'b0;
        #1;
        oe_s = ext_addr_oe;
        doe_s = ext_data_oe;
        ad_s = ext_addr;
        @(posedge aclk);
        #1;
        rv_s = cpu_rvalid;
        rd_s = cpu_rdata;
        @(posedge aclk);
    endtask

    // Counts clock enable ticks and phase steps over 40 cycles
    task automatic cnt;
        logic [1:0] p;
        n = 0;
        ph = 0;
        repeat (4) @(posedge aclk);
        #1;
        p = {ext_phase2, ext_phase4};
        repeat (40) begin
            @(posedge aclk);
            #1;
            n += int'(cpu_clk_en === 1'b1);
            ph += int'({ext_phase2, ext_phase4} !== p);
            p = {ext_phase2, ext_phase4};
        end
        @(posedge aclk);
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        print_verdict();
    end

    initial begin
        rst(1'b1);
        chk(32'(clock_gate_port_bit), 32'h1);
        chk(32'(test_mode), 32'h0);
        axr(A_CTL);
        chk(rd, 32'h0);
        cpu(1'b0, 16'h1234, 8'h00);
        chk(32'(oe_s), 32'h0);
        axw(A_SET, 32'h20, 4'h1);
        axr(A_CTL);
        chk(rd, 32'h20);
        cpu(1'b0, 16'h1234, 8'h00);
        chk(32'({oe_s, ad_s}), 32'h11234);
        chk(32'(rd_s), 32'h6e);
        cpu(1'b1, 16'h1234, 8'h99);
        chk(32'({doe_s, ext_data_o}), 32'h199);
        chk(32'(ext_read), 32'h0);
        cpu(1'b0, 16'h1234, 8'h00);
        chk(32'(rd_s), 32'h99);
        cpu(1'b0, 16'hfffc, 8'h00);
        chk(32'({oe_s, rd_s}), 32'h1c3);
        cpu(1'b0, 16'h00c5, 8'h00);
        chk(32'(rd_s), 32'hc3);
        cpu(1'b0, 16'h01c5, 8'h00);
        chk(32'(rd_s), 32'hc3);
        cpu(1'b0, 16'h00f8, 8'h00);
        chk(32'(rd_s), 32'hc3);
        cpu(1'b0, 16'h0005, 8'h00);
        chk(32'(rd_s), 32'h5f);
        axw(A_TMR, 32'h1234, 4'h3);
        axr(A_TMR);
        chk(rd, 32'h1234);
        axw(A_TMRH, 32'hab, 4'h1);
        chk(32'(wr), 32'h0);
        axr(A_TMR);
        chk(rd, 32'hab34);
        axr(12'h000);
        chk(32'(rr), 32'h3);
        chk(rd, 32'h0);
        axw(12'h004, 32'hff, 4'h1);
        chk(32'(wr), 32'h3);
        axw(A_TMR, 32'h3, 4'h3);
        axw(A_SET, 32'h08, 4'h1);
        axr(A_CTL);
        chk(rd, 32'h28);
        cnt();
        chk(32'(n), 32'd10);
        chk(32'(ph), 32'd10);
        axw(A_CLR, 32'h08, 4'h1);
        axr(A_CTL);
        chk(rd, 32'h20);
        cnt();
        chk(32'(n), 32'd40);
        axw(A_CLR, 32'h20, 4'h1);
        cpu(1'b0, 16'h1234, 8'h00);
        chk(32'(oe_s), 32'h0);
        axw(A_SET, 32'h20, 4'h1);
        cpu(1'b0, 16'h1234, 8'h00);
        chk(32'(oe_s), 32'h1);
        power_fail <= 1'b1;
        repeat (3) @(posedge aclk);
        axr(A_CTL);
        chk(rd, 32'ha0);
        power_fail <= 1'b0;
        repeat (3) @(posedge aclk);
        axr(A_CTL);
        chk(rd, 32'h20);
        axr(A_PA);
        chk(rd, 32'h3c);
        axw(A_PA, 32'h0e, 4'h1);
        axr(A_PA);
        chk(rd, 32'h0c);
        chk(32'(clock_gate_port_bit), 32'h0);
        rst(1'b0);
        chk(32'(clock_gate_port_bit), 32'h1);
        chk(32'(test_mode), 32'h1);
        cpu(1'b0, 16'hfffc, 8'h00);
        chk(32'({oe_s, rd_s}), 32'h1a6);
        port_d_bit_one <= 1'b0;
        repeat (2) @(posedge aclk);
        cpu(1'b0, 16'hfffc, 8'h00);
        chk(32'({oe_s, ad_s, rd_s}), 32'h1fffcc3);
        chk(32'(rv_s), 32'h1);
        print_verdict();
    end
endmodule
